// [verilog/fbdc_defines.svh]
// Purpose: offsets, field positions, reset values and encodings of the reference converter control
// Assumes: classic wishbone, 32-bit data, one register per aligned word
// Notes: definitions only
`ifndef FBDC_DEFINES_SVH
`define FBDC_DEFINES_SVH
`define FBDC_OFS_CTRL0      4'h0
`define FBDC_OFS_LEVEL      4'h4
`define FBDC_OFS_AUX        4'h8
`define FBDC_OFS_STATUS     4'hc
`define FBDC_BIT_ENABLE     7
`define FBDC_BIT_OE_ONE     5
`define FBDC_BIT_OE_TWO     4
`define FBDC_POS_PSS_HI     3
`define FBDC_POS_PSS_LO     2
`define FBDC_BIT_NSS        0
`define FBDC_BIT_IDLE_RAIL  0
`define FBDC_RST_CTRL0      8'h00
`define FBDC_RST_LEVEL      5'h00
`define FBDC_CTRL0_MASK     8'hbd
`define FBDC_LEVEL_MASK     8'h1f
`define FBDC_PSS_SUPPLY     2'h0
`define FBDC_PSS_EXT_HIGH   2'h1
`define FBDC_PSS_FIXED_BUF  2'h2
`define FBDC_PSS_RESERVED   2'h3
`define FBDC_LEVEL_ALL_ONE  5'h1f
`define FBDC_LEVEL_ALL_ZERO 5'h00
`endif

// [verilog/fbdc_pkg.sv]
// Purpose: types shared by the reference converter control files
// Assumes: nothing
// Notes: no constants here, those live in the defines header
package fbdc_pkg;
	typedef enum logic [1:0] {
		FBDC_POS_SUPPLY,
		FBDC_POS_EXT_HIGH,
		FBDC_POS_FIXED_BUF,
		FBDC_POS_NONE
	} fbdc_pos_src_type;

	typedef enum logic [1:0] {
		FBDC_OUT_OFF,
		FBDC_OUT_LADDER,
		FBDC_OUT_POS_RAIL,
		FBDC_OUT_NEG_RAIL
	} fbdc_out_mode_type;

	typedef struct packed {
		logic       converter_enable;
		logic       pin_one_output_enable;
		logic       pin_two_output_enable;
		logic [1:0] positive_source_select;
		logic       negative_source_select;
		logic       idle_rail_select;
		logic [4:0] level_code;
	} fbdc_cfg_type;

	typedef struct packed {
		logic analog_connect;
		logic digital_driver_off;
		logic input_detect_off;
	} fbdc_pin_ctl_type;
endpackage

// [verilog/fbdc_pin_override.sv]
// Purpose: one analog pin override: routes the level and kills digital paths
// Assumes: the port logic on the pin obeys the off controls
// Notes: combinational
`timescale 1ns/1ps
`include "fbdc_defines.svh"
module fbdc_pin_override (
	input  wire logic                      i_output_enable,
	input  wire logic                      i_pin_digital_in,
	output fbdc_pkg::fbdc_pin_ctl_type     o_ctl,
	output logic                           o_pin_read
);
	always_comb begin
		o_ctl.analog_connect     = i_output_enable;
		o_ctl.digital_driver_off = i_output_enable;
		o_ctl.input_detect_off   = i_output_enable;
		o_pin_read               = i_output_enable ? 1'b0 : i_pin_digital_in;
	end
endmodule

// [verilog/fbdc_level_decode.sv]
// Purpose: decodes settings into positive source, output mode and ladder tap
// Assumes: software never writes the reserved positive source code
// Notes: combinational
`timescale 1ns/1ps
`include "fbdc_defines.svh"
module fbdc_level_decode (
	input  fbdc_pkg::fbdc_cfg_type         i_cfg,
	output fbdc_pkg::fbdc_pos_src_type     o_pos_src,
	output fbdc_pkg::fbdc_out_mode_type    o_mode,
	output logic [4:0]                     o_tap
);
	always_comb begin
		case (i_cfg.positive_source_select)
			`FBDC_PSS_SUPPLY:    o_pos_src = fbdc_pkg::FBDC_POS_SUPPLY;
			`FBDC_PSS_EXT_HIGH:  o_pos_src = fbdc_pkg::FBDC_POS_EXT_HIGH;
			`FBDC_PSS_FIXED_BUF: o_pos_src = fbdc_pkg::FBDC_POS_FIXED_BUF;
			default:             o_pos_src = fbdc_pkg::FBDC_POS_NONE;
		endcase
		o_tap = i_cfg.level_code;
		if (i_cfg.converter_enable) begin
			o_mode = fbdc_pkg::FBDC_OUT_LADDER;
		end else if (i_cfg.idle_rail_select && i_cfg.level_code == `FBDC_LEVEL_ALL_ONE) begin
			o_mode = fbdc_pkg::FBDC_OUT_POS_RAIL;
		end else if (!i_cfg.idle_rail_select && i_cfg.level_code == `FBDC_LEVEL_ALL_ZERO) begin
			o_mode = fbdc_pkg::FBDC_OUT_NEG_RAIL;
		end else begin
			o_mode = fbdc_pkg::FBDC_OUT_OFF;
		end
	end
endmodule

// [verilog/fbdc_top.sv]
// Purpose: control logic of a 5-bit ratiometric reference converter, wishbone slave
// Assumes: classic wishbone, 32-bit data, reset covers every device reset
// Notes: sleep is not a reset, so registers simply hold through it
`timescale 1ns/1ps
`include "fbdc_defines.svh"
module fbdc_top (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [3:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	input  wire logic        I_SLEEP,
	input  wire logic        I_PIN_ONE_IN,
	input  wire logic        I_PIN_TWO_IN,
	output logic [31:0]      O_WB_DAT,
	output logic             O_WB_ACK,
	output logic             O_WB_ERR,
	output logic             O_CONVERTER_ENABLE,
	output logic [1:0]       O_POSITIVE_SOURCE,
	output logic             O_NEGATIVE_SOURCE,
	output logic [4:0]       O_LADDER_TAP,
	output logic [1:0]       O_OUT_MODE,
	output logic             O_ANALOG_OUT_PIN_ONE_CONNECT,
	output logic             O_ANALOG_OUT_PIN_TWO_CONNECT,
	output logic             O_PIN_ONE_OE_N,
	output logic             O_PIN_TWO_OE_N,
	output logic             O_PIN_ONE_DETECT_OFF,
	output logic             O_PIN_TWO_DETECT_OFF,
	output logic             O_PIN_ONE_READ,
	output logic             O_PIN_TWO_READ
);
	logic                          converter_enable;
	logic                          pin_one_output_enable;
	logic                          pin_two_output_enable;
	logic [1:0]                    positive_source_select;
	logic                          negative_source_select;
	logic                          idle_rail_select;
	logic [4:0]                    level_code;
	logic [2:0]                    pin_one_sync;
	logic [2:0]                    pin_two_sync;
	logic                          pin_one_level;
	logic                          pin_two_level;
	logic                          wb_req;
	logic                          wb_hit;
	logic                          wb_wr;
	logic [31:0]                   next_rdata;
	logic [7:0]                    ctrl0_view;
	fbdc_pkg::fbdc_cfg_type        cfg;
	fbdc_pkg::fbdc_pos_src_type    pos_src;
	fbdc_pkg::fbdc_out_mode_type   mode;
	logic [4:0]                    tap;
	fbdc_pkg::fbdc_pin_ctl_type    ctl_one;
	fbdc_pkg::fbdc_pin_ctl_type    ctl_two;
	logic                          read_one;
	logic                          read_two;

	// single-cycle answer: request seen, ack next edge, dropped the edge after
	assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
	assign wb_hit = (I_WB_ADR == `FBDC_OFS_CTRL0) || (I_WB_ADR == `FBDC_OFS_LEVEL) ||
		(I_WB_ADR == `FBDC_OFS_AUX) || (I_WB_ADR == `FBDC_OFS_STATUS);
	assign wb_wr  = wb_req && wb_hit && I_WB_WE && I_WB_SEL[0];

	always_comb begin
		ctrl0_view = `FBDC_RST_CTRL0;
		ctrl0_view[`FBDC_BIT_ENABLE] = converter_enable;
		ctrl0_view[`FBDC_BIT_OE_ONE] = pin_one_output_enable;
		ctrl0_view[`FBDC_BIT_OE_TWO] = pin_two_output_enable;
		ctrl0_view[`FBDC_POS_PSS_HI:`FBDC_POS_PSS_LO] = positive_source_select;
		ctrl0_view[`FBDC_BIT_NSS] = negative_source_select;
	end

	always_comb begin
		next_rdata = 32'h0;
		case (I_WB_ADR)
			`FBDC_OFS_CTRL0:  next_rdata[7:0] = ctrl0_view;
			`FBDC_OFS_LEVEL:  next_rdata[7:0] = {3'h0, level_code};
			`FBDC_OFS_AUX:    next_rdata[`FBDC_BIT_IDLE_RAIL] = idle_rail_select;
			`FBDC_OFS_STATUS: next_rdata[3:0] = {O_OUT_MODE, O_PIN_TWO_READ, O_PIN_ONE_READ};
			default:          next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_WB_ACK <= 1'b0;
			O_WB_ERR <= 1'b0;
			O_WB_DAT <= 32'h0;
		end else begin
			O_WB_ACK <= wb_req && wb_hit;
			O_WB_ERR <= wb_req && !wb_hit;
			O_WB_DAT <= (wb_req && wb_hit && !I_WB_WE) ? next_rdata : 32'h0;
		end
	end

	// control 0: only a reset clears it; sleep and wake leave it alone
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			converter_enable       <= 1'b0;
			pin_one_output_enable  <= 1'b0;
			pin_two_output_enable  <= 1'b0;
			positive_source_select <= 2'h0;
			negative_source_select <= 1'b0;
		end else if (wb_wr && I_WB_ADR == `FBDC_OFS_CTRL0) begin
			converter_enable       <= I_WB_DAT[`FBDC_BIT_ENABLE];
			pin_one_output_enable  <= I_WB_DAT[`FBDC_BIT_OE_ONE];
			pin_two_output_enable  <= I_WB_DAT[`FBDC_BIT_OE_TWO];
			positive_source_select <= I_WB_DAT[`FBDC_POS_PSS_HI:`FBDC_POS_PSS_LO];
			negative_source_select <= I_WB_DAT[`FBDC_BIT_NSS];
		end
	end

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			level_code <= `FBDC_RST_LEVEL;
		end else if (wb_wr && I_WB_ADR == `FBDC_OFS_LEVEL) begin
			level_code <= I_WB_DAT[4:0];
		end
	end

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			idle_rail_select <= 1'b0;
		end else if (wb_wr && I_WB_ADR == `FBDC_OFS_AUX) begin
			idle_rail_select <= I_WB_DAT[`FBDC_BIT_IDLE_RAIL];
		end
	end

	// pin inputs come from outside: three stages, change taken when last two agree
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			pin_one_sync  <= 3'h0;
			pin_two_sync  <= 3'h0;
			pin_one_level <= 1'b0;
			pin_two_level <= 1'b0;
		end else begin
			pin_one_sync <= {pin_one_sync[1:0], I_PIN_ONE_IN};
			pin_two_sync <= {pin_two_sync[1:0], I_PIN_TWO_IN};
			if (pin_one_sync[1] == pin_one_sync[2]) begin
				pin_one_level <= pin_one_sync[2];
			end
			if (pin_two_sync[1] == pin_two_sync[2]) begin
				pin_two_level <= pin_two_sync[2];
			end
		end
	end

	always_comb begin
		cfg.converter_enable       = converter_enable;
		cfg.pin_one_output_enable  = pin_one_output_enable;
		cfg.pin_two_output_enable  = pin_two_output_enable;
		cfg.positive_source_select = positive_source_select;
		cfg.negative_source_select = negative_source_select;
		cfg.idle_rail_select       = idle_rail_select;
		cfg.level_code             = level_code;
	end

	fbdc_level_decode u_decode (
		.i_cfg     (cfg),
		.o_pos_src (pos_src),
		.o_mode    (mode),
		.o_tap     (tap)
	);

	fbdc_pin_override u_pin_one (
		.i_output_enable  (pin_one_output_enable),
		.i_pin_digital_in (pin_one_level),
		.o_ctl            (ctl_one),
		.o_pin_read       (read_one)
	);

	fbdc_pin_override u_pin_two (
		.i_output_enable  (pin_two_output_enable),
		.i_pin_digital_in (pin_two_level),
		.o_ctl            (ctl_two),
		.o_pin_read       (read_two)
	);

	// analog controls registered; follow the registers by one cycle
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_CONVERTER_ENABLE           <= 1'b0;
			O_POSITIVE_SOURCE            <= 2'h0;
			O_NEGATIVE_SOURCE            <= 1'b0;
			O_LADDER_TAP                 <= 5'h0;
			O_OUT_MODE                   <= 2'h0;
			O_ANALOG_OUT_PIN_ONE_CONNECT <= 1'b0;
			O_ANALOG_OUT_PIN_TWO_CONNECT <= 1'b0;
			O_PIN_ONE_OE_N               <= 1'b1;
			O_PIN_TWO_OE_N               <= 1'b1;
			O_PIN_ONE_DETECT_OFF         <= 1'b0;
			O_PIN_TWO_DETECT_OFF         <= 1'b0;
			O_PIN_ONE_READ               <= 1'b0;
			O_PIN_TWO_READ               <= 1'b0;
		end else begin
			O_CONVERTER_ENABLE           <= converter_enable;
			O_POSITIVE_SOURCE            <= pos_src;
			O_NEGATIVE_SOURCE            <= negative_source_select;
			O_LADDER_TAP                 <= tap;
			O_OUT_MODE                   <= mode;
			O_ANALOG_OUT_PIN_ONE_CONNECT <= ctl_one.analog_connect;
			O_ANALOG_OUT_PIN_TWO_CONNECT <= ctl_two.analog_connect;
			O_PIN_ONE_OE_N               <= 1'b1;
			O_PIN_TWO_OE_N               <= 1'b1;
			O_PIN_ONE_DETECT_OFF         <= ctl_one.input_detect_off;
			O_PIN_TWO_DETECT_OFF         <= ctl_two.input_detect_off;
			O_PIN_ONE_READ               <= read_one;
			O_PIN_TWO_READ               <= read_two;
		end
	end
endmodule

// [bench/fbdc_chk.sv]
// Purpose: concurrent checks on the converter control ports
// Assumes: one clock, asynchronous active-high reset
// Notes: bound into fbdc_top
`timescale 1ns/1ps
module fbdc_chk (
	input wire logic        I_CORE_CLK,
	input wire logic        I_RST,
	input wire logic        I_WB_CYC,
	input wire logic        I_WB_STB,
	input wire logic        I_WB_WE,
	input wire logic [3:0]  I_WB_ADR,
	input wire logic [31:0] O_WB_DAT,
	input wire logic        O_WB_ACK,
	input wire logic        O_WB_ERR,
	input wire logic        O_CONVERTER_ENABLE,
	input wire logic [4:0]  O_LADDER_TAP,
	input wire logic [1:0]  O_OUT_MODE,
	input wire logic        O_ANALOG_OUT_PIN_ONE_CONNECT,
	input wire logic        O_ANALOG_OUT_PIN_TWO_CONNECT,
	input wire logic        O_PIN_ONE_OE_N,
	input wire logic        O_PIN_TWO_OE_N,
	input wire logic        O_PIN_ONE_DETECT_OFF,
	input wire logic        O_PIN_TWO_DETECT_OFF,
	input wire logic        O_PIN_ONE_READ
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	logic take;
	assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
	bus_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK && !O_WB_ERR) else $error("ack longer than one cycle");
	ack_answer_a: assert property (take && I_WB_ADR[1:0] == 2'h0 |=> O_WB_ACK && !O_WB_ERR) else $error("no ack");
	err_answer_a: assert property (take && I_WB_ADR[1:0] != 2'h0 |=> O_WB_ERR && !O_WB_ACK) else $error("no err");
	ctrl_reserved_a: assert property (O_WB_ACK && $past(I_WB_ADR) == 4'h0 && !$past(I_WB_WE)
		|-> O_WB_DAT[6] == 1'b0 && O_WB_DAT[1] == 1'b0 && O_WB_DAT[31:8] == 24'h0) else $error("reserved bit set");
	detect_routed_a: assert property (O_PIN_ONE_DETECT_OFF == O_ANALOG_OUT_PIN_ONE_CONNECT
		&& O_PIN_TWO_DETECT_OFF == O_ANALOG_OUT_PIN_TWO_CONNECT) else $error("detector not tied to routing");
	driver_off_a: assert property (O_PIN_ONE_OE_N && O_PIN_TWO_OE_N) else $error("pin driver enabled");
	read_zero_a: assert property (O_ANALOG_OUT_PIN_ONE_CONNECT && $past(O_ANALOG_OUT_PIN_ONE_CONNECT)
		|-> !O_PIN_ONE_READ) else $error("routed pin reads one");
	ladder_on_a: assert property (O_CONVERTER_ENABLE && $past(O_CONVERTER_ENABLE)
		|-> O_OUT_MODE == 2'h1) else $error("enabled without ladder mode");
	rail_high_a: assert property (O_OUT_MODE == 2'h2 |-> O_LADDER_TAP == 5'h1f && !O_CONVERTER_ENABLE)
		else $error("positive rail mode wrong");
	rail_low_a: assert property (O_OUT_MODE == 2'h3 |-> O_LADDER_TAP == 5'h00 && !O_CONVERTER_ENABLE)
		else $error("negative rail mode wrong");
	reset_clear_a: assert property ($fell(I_RST) |-> !O_CONVERTER_ENABLE && O_LADDER_TAP == 5'h00
		&& !O_ANALOG_OUT_PIN_ONE_CONNECT && !O_ANALOG_OUT_PIN_TWO_CONNECT) else $error("reset left outputs set");
	cover property (O_OUT_MODE == 2'h2);
	cover property (O_WB_ERR);
	cover property (O_ANALOG_OUT_PIN_TWO_CONNECT && O_CONVERTER_ENABLE);
endmodule
bind fbdc_top fbdc_chk i_fbdc_chk (.*);

// [bench/fbdc_top_test.sv]
// Purpose: self-checking bench of the converter control
// Assumes: outputs settle one edge after a register write
// Notes: byte select held at all ones except one level write with byte 0 deselected
`timescale 1ns/1ps
`include "fbdc_defines.svh"
module fbdc_top_test;
	logic        I_CORE_CLK = 1'b0, I_RST = 1'b1, I_WB_CYC = 1'b0, I_WB_STB = 1'b0, I_WB_WE = 1'b0;
	logic [3:0]  I_WB_ADR = 4'h0, I_WB_SEL = 4'hf;
	logic [31:0] I_WB_DAT = 32'h0, O_WB_DAT, rd;
	logic        I_SLEEP = 1'b0, I_PIN_ONE_IN = 1'b0, I_PIN_TWO_IN = 1'b0, O_WB_ACK, O_WB_ERR, O_CONVERTER_ENABLE;
	logic [1:0]  O_POSITIVE_SOURCE, O_OUT_MODE;
	logic [4:0]  O_LADDER_TAP;
	logic        O_NEGATIVE_SOURCE, O_ANALOG_OUT_PIN_ONE_CONNECT, O_ANALOG_OUT_PIN_TWO_CONNECT, O_PIN_ONE_OE_N;
	logic        O_PIN_TWO_OE_N, O_PIN_ONE_DETECT_OFF, O_PIN_TWO_DETECT_OFF, O_PIN_ONE_READ, O_PIN_TWO_READ, rerr;
	int          error_cnt = 0, comparisons = 0;
	fbdc_top i_fbdc_top (.*);
	always #20 I_CORE_CLK = ~I_CORE_CLK;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge I_CORE_CLK);
		I_WB_CYC <= 1'b1;
		I_WB_STB <= 1'b1;
		I_WB_WE <= w;
		I_WB_ADR <= a;
		I_WB_DAT <= d;
		do begin
			@(posedge I_CORE_CLK);
		end while (!(O_WB_ACK === 1'b1 || O_WB_ERR === 1'b1));
		rd = O_WB_DAT;
		rerr = O_WB_ERR;
		I_WB_CYC <= 1'b0;
		I_WB_STB <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
		chk("write err", 32'h0, rerr);
		@(posedge I_CORE_CLK);
	endtask
	task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk("read err", 32'h0, rerr);
		chk(what, exp, rd);
	endtask
	task automatic t_reset;
		chk("enable", 32'h0, O_CONVERTER_ENABLE);
		chk("routing", 32'h0, {O_ANALOG_OUT_PIN_ONE_CONNECT, O_ANALOG_OUT_PIN_TWO_CONNECT});
		chk("driver oe_n", 32'h3, {O_PIN_ONE_OE_N, O_PIN_TWO_OE_N});
		rdchk("ctrl0", `FBDC_OFS_CTRL0, 32'h0);
		rdchk("level", `FBDC_OFS_LEVEL, 32'h0);
		rdchk("aux", `FBDC_OFS_AUX, 32'h0);
	endtask
	task automatic t_regs;
		for (int p = 0; p < 3; p++) begin
			wr(`FBDC_OFS_CTRL0, {24'hffffff, 4'hc, p[1:0], 1'b1, p[0]});
			rdchk("ctrl0", `FBDC_OFS_CTRL0, {24'h0, 4'h8, p[1:0], 1'b0, p[0]});
			chk("enable", 32'h1, O_CONVERTER_ENABLE);
			chk("positive source", p, O_POSITIVE_SOURCE);
			chk("negative source", p & 1, O_NEGATIVE_SOURCE);
		end
		wr(`FBDC_OFS_LEVEL, 32'hff);
		rdchk("level", `FBDC_OFS_LEVEL, 32'h1f);
		chk("tap", 32'h1f, O_LADDER_TAP);
		wr(`FBDC_OFS_LEVEL, 32'h0);
		chk("mode", 32'h1, O_OUT_MODE);
		I_WB_SEL <= 4'he;
		wr(`FBDC_OFS_LEVEL, 32'h7);
		I_WB_SEL <= 4'hf;
		rdchk("level", `FBDC_OFS_LEVEL, 32'h0);
		wr(`FBDC_OFS_CTRL0, 32'h0);
		chk("enable", 32'h0, O_CONVERTER_ENABLE);
	endtask
	task automatic t_rails;
		for (int i = 0; i < 4; i++) begin
			wr(`FBDC_OFS_AUX, i >> 1);
			wr(`FBDC_OFS_LEVEL, (i & 1) ? 32'h1f : 32'h0);
			chk("mode", (i == 3) ? 32'h2 : (i == 0) ? 32'h3 : 32'h0, O_OUT_MODE);
		end
	endtask
	task automatic t_pins;
		I_PIN_ONE_IN <= 1'b1;
		I_PIN_TWO_IN <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wr(`FBDC_OFS_CTRL0, k ? 32'h10 : 32'h20);
			repeat (8) @(posedge I_CORE_CLK);
			chk("routing", k ? 32'h1 : 32'h2, {O_ANALOG_OUT_PIN_ONE_CONNECT, O_ANALOG_OUT_PIN_TWO_CONNECT});
			chk("detect off", k ? 32'h1 : 32'h2, {O_PIN_ONE_DETECT_OFF, O_PIN_TWO_DETECT_OFF});
			chk("port read", k ? 32'h2 : 32'h1, {O_PIN_ONE_READ, O_PIN_TWO_READ});
			rdchk("status", `FBDC_OFS_STATUS, k ? 32'h9 : 32'ha);
		end
	endtask
	task automatic t_sleep_reset;
		wr(`FBDC_OFS_CTRL0, 32'h35);
		wr(`FBDC_OFS_LEVEL, 32'h1f);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped err", 32'h1, rerr);
		I_SLEEP <= 1'b1;
		repeat (5) @(posedge I_CORE_CLK);
		I_SLEEP <= 1'b0;
		rdchk("ctrl0", `FBDC_OFS_CTRL0, 32'h35);
		wr(`FBDC_OFS_CTRL0, 32'hb5);
		I_RST <= 1'b1;
		repeat (2) @(posedge I_CORE_CLK);
		I_RST <= 1'b0;
		@(posedge I_CORE_CLK);
		chk("outputs", 32'h0, {O_CONVERTER_ENABLE, O_ANALOG_OUT_PIN_ONE_CONNECT, O_ANALOG_OUT_PIN_TWO_CONNECT,
			O_LADDER_TAP});
		rdchk("level", `FBDC_OFS_LEVEL, 32'h0);
		rdchk("ctrl0", `FBDC_OFS_CTRL0, 32'h0);
		rdchk("aux", `FBDC_OFS_AUX, 32'h0);
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge I_CORE_CLK);
		chk("watchdog", 32'h0, 32'h1);
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge I_CORE_CLK);
		I_RST <= 1'b0;
		@(posedge I_CORE_CLK);
		t_reset;
		t_regs;
		t_rails;
		t_pins;
		t_sleep_reset;
		tally_and_finish;
	end
endmodule
